/* File: rtl/dbc_regs.svh */
// constants for the ddr bank command state block
// assumes a 40 MHz sys_clk; commands arrive already synchronous
//
// Overview of operation
// - bank command rules only with clock enable high twice
// - idle after row close; active after row delay
// - burst state until burst ends or is cut
// - read autoprecharge: access then precharge period
// - write autoprecharge precharge starts after write recovery
// - other banks accept commands during autoprecharge
// - burst stop acts on bursting bank only
// - clock enable levels keep or exit low power
// - clock enable fall enters power-down or self refresh
// - self refresh exit relocks loop, wait 200
// - chip select high registers nothing new
// - no-op registers nothing, ongoing work continues
// - mode load captures address, then wait
// - open row command opens addressed row
// - read or write starts burst at column
// - close_all_select chooses one or all banks
// - command encoding on four strobes
// - bank zero mode load keeps value, reset bit clears
`ifndef DBC_REGS_SVH
`define DBC_REGS_SVH
`define DBC_CLK_MHZ 40
`define DBC_ROW_CLOSE_NS 15
`define DBC_ROW_TO_COL_NS 15
`define DBC_WRITE_REC_NS 15
`define DBC_MODE_LOAD_NS 10
`define DBC_REFRESH_NS 70
`define DBC_SR_EXIT_NS 75
`define DBC_CYC(ns) (((ns) * `DBC_CLK_MHZ + 999) / 1000)
`define DBC_DLL_LOCK_CYC 200
`define DBC_CLOSE_ALL_BIT 10
`define DBC_BL_LSB 0
`define DBC_CL_LSB 4
`define DBC_DLL_RESET_BIT 8
`define DBC_MODE_RESET 14'h0000
`endif

/* File: rtl/dbc_pkg.sv */
// types for the ddr bank command state block
// assumes dbc_regs.svh supplies the numbers
package dbc_pkg;
  typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_BST,
    CMD_MLOAD, CMD_REF} dbc_cmd_type;
  typedef enum logic [3:0] {BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
    BK_READ_AP, BK_WRITE_AP, BK_PRECHARGING} dbc_bank_type;
  typedef enum logic [2:0] {PW_NORMAL, PW_PRE_PD, PW_ACT_PD, PW_SELF_REF, PW_SR_EXIT,
    PW_REFRESH, PW_MODE_LOAD} dbc_power_type;
  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
  } dbc_strobe_type;
  typedef struct packed {
    logic [1:0] bankSelect;
    logic [13:0] addr;
  } dbc_addr_type;
endpackage

/* File: rtl/dbc_bank_state.sv */
// bank state tracker and command decoder of a four-bank ddr dram
// assumes commands are sampled on sys_clk with clock enable alongside
`timescale 1ns/1ps
`include "dbc_regs.svh"
module dbc_bank_state #(
  parameter int NUM_BANKS = 4,
  parameter int ROW_BITS = 14,
  parameter int ROW_CLOSE_CYC = `DBC_CYC(`DBC_ROW_CLOSE_NS),
  parameter int ROW_TO_COL_CYC = `DBC_CYC(`DBC_ROW_TO_COL_NS),
  parameter int WRITE_REC_CYC = `DBC_CYC(`DBC_WRITE_REC_NS),
  parameter int MODE_LOAD_CYC = `DBC_CYC(`DBC_MODE_LOAD_NS),
  parameter int REFRESH_CYC = `DBC_CYC(`DBC_REFRESH_NS),
  parameter int SR_EXIT_CYC = `DBC_CYC(`DBC_SR_EXIT_NS)
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clockEnable,
  input wire dbc_pkg::dbc_strobe_type strobes,
  input wire dbc_pkg::dbc_addr_type address,
  output logic [4*NUM_BANKS-1:0] bankStates,
  output logic [ROW_BITS*NUM_BANKS-1:0] openRows,
  output logic [ROW_BITS-1:0] modeReg,
  output logic [ROW_BITS-1:0] extModeReg,
  output logic [ROW_BITS-1:0] burstColumn,
  output dbc_pkg::dbc_power_type powerState,
  output logic dllLocked,
  output logic illegalCmd
);
  localparam int CW = 8;
  dbc_pkg::dbc_bank_type bank_q [NUM_BANKS];
  logic [CW-1:0] bankCnt_q [NUM_BANKS];
  logic [CW-1:0] pwrCnt_q;
  logic [7:0] dllCnt_q;
  logic cke_q;
  logic [1:0] burstBank_q;
  logic burstLive_q;
  dbc_pkg::dbc_power_type pwr_q;
  dbc_pkg::dbc_cmd_type cmd;
  logic cmdRules;
  logic allIdle;
  logic anyOpen;
  logic [3:0] burstHalf;
  logic [1:0] bs;

  assign bs = address.bankSelect;

  // decode the four strobes
  always_comb
  begin
    cmd = dbc_pkg::CMD_NOP;
    if (!strobes.csN)
    begin
      case ({strobes.rasN, strobes.casN, strobes.weN})
        3'b011: cmd = dbc_pkg::CMD_ACT;
        3'b101: cmd = dbc_pkg::CMD_READ;
        3'b100: cmd = dbc_pkg::CMD_WRITE;
        3'b010: cmd = dbc_pkg::CMD_PRE;
        3'b110: cmd = dbc_pkg::CMD_BST;
        3'b000: cmd = dbc_pkg::CMD_MLOAD;
        3'b001: cmd = dbc_pkg::CMD_REF;
        default: cmd = dbc_pkg::CMD_NOP;
      endcase
    end
  end

  always_comb
  begin
    allIdle = 1'b1;
    anyOpen = 1'b0;
    for (int i = 0; i < NUM_BANKS; i++)
    begin
      if (bank_q[i] != dbc_pkg::BK_IDLE)
        allIdle = 1'b0;
      if (bank_q[i] != dbc_pkg::BK_IDLE && bank_q[i] != dbc_pkg::BK_PRECHARGING)
        anyOpen = 1'b1;
    end
  end

  // burst length 2,4,8 from code 1,2,3; half in clocks
  assign burstHalf = 4'(1 << (modeReg[`DBC_BL_LSB +: 3] - 3'd1));

  assign cmdRules = cke_q && clockEnable && pwr_q == dbc_pkg::PW_NORMAL;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      cke_q <= 1'b0;
    else
      cke_q <= clockEnable;
  end

  // power state from previous and current clock enable
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      pwr_q <= dbc_pkg::PW_NORMAL;
      pwrCnt_q <= '0;
    end
    else
    begin
      if (pwrCnt_q != '0)
        pwrCnt_q <= pwrCnt_q - 1'b1;
      case (pwr_q)
        dbc_pkg::PW_NORMAL:
          if (cke_q && !clockEnable)
          begin
            if (cmd == dbc_pkg::CMD_REF && allIdle)
              pwr_q <= dbc_pkg::PW_SELF_REF;
            else if (cmd == dbc_pkg::CMD_NOP)
              pwr_q <= anyOpen ? dbc_pkg::PW_ACT_PD : dbc_pkg::PW_PRE_PD;
          end
          else if (cmdRules && cmd == dbc_pkg::CMD_REF && allIdle)
          begin
            pwr_q <= dbc_pkg::PW_REFRESH;
            pwrCnt_q <= CW'(REFRESH_CYC);
          end
          else if (cmdRules && cmd == dbc_pkg::CMD_MLOAD && allIdle)
          begin
            pwr_q <= dbc_pkg::PW_MODE_LOAD;
            pwrCnt_q <= CW'(MODE_LOAD_CYC);
          end
        dbc_pkg::PW_PRE_PD, dbc_pkg::PW_ACT_PD:
          if (!cke_q && clockEnable && cmd == dbc_pkg::CMD_NOP)
            pwr_q <= dbc_pkg::PW_NORMAL;
        dbc_pkg::PW_SELF_REF:
          if (!cke_q && clockEnable && cmd == dbc_pkg::CMD_NOP)
          begin
            pwr_q <= dbc_pkg::PW_SR_EXIT;
            pwrCnt_q <= CW'(SR_EXIT_CYC);
          end
        dbc_pkg::PW_SR_EXIT, dbc_pkg::PW_REFRESH, dbc_pkg::PW_MODE_LOAD:
          if (pwrCnt_q <= CW'(1))
            pwr_q <= dbc_pkg::PW_NORMAL;
        default: pwr_q <= dbc_pkg::PW_NORMAL;
      endcase
    end
  end

  // delay-locked loop relock after self refresh or reset bit
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      dllCnt_q <= '0;
    else if (pwr_q == dbc_pkg::PW_SR_EXIT && pwrCnt_q == CW'(SR_EXIT_CYC))
      dllCnt_q <= 8'(`DBC_DLL_LOCK_CYC);
    else if (cmdRules && cmd == dbc_pkg::CMD_MLOAD && allIdle && bs == 2'b00
             && address.addr[`DBC_DLL_RESET_BIT])
      dllCnt_q <= 8'(`DBC_DLL_LOCK_CYC);
    else if (dllCnt_q != '0 && clockEnable)
      dllCnt_q <= dllCnt_q - 1'b1;
  end

  // mode registers
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      modeReg <= `DBC_MODE_RESET;
      extModeReg <= `DBC_MODE_RESET;
    end
    else if (cmdRules && cmd == dbc_pkg::CMD_MLOAD && allIdle)
    begin
      if (bs == 2'b00)
      begin
        modeReg <= address.addr;
        modeReg[`DBC_DLL_RESET_BIT] <= 1'b0;
      end
      else if (bs == 2'b01)
        extModeReg <= address.addr;
    end
  end

  // which bank holds the burst a stop would cut
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      burstBank_q <= '0;
      burstLive_q <= 1'b0;
    end
    else if (cmdRules && cmd == dbc_pkg::CMD_READ)
    begin
      burstBank_q <= bs;
      burstLive_q <= !address.addr[`DBC_CLOSE_ALL_BIT];
    end
    else if (cmdRules && cmd == dbc_pkg::CMD_BST)
      burstLive_q <= 1'b0;
  end

  // per-bank state machines
  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_bank
    logic hit;
    logic ap;
    assign hit = cmdRules && bs == 2'(b);
    assign ap = address.addr[`DBC_CLOSE_ALL_BIT];
    always_ff @(posedge sys_clk)
    begin
      if (!rstn)
      begin
        bank_q[b] <= dbc_pkg::BK_IDLE;
        bankCnt_q[b] <= '0;
        openRows[b*ROW_BITS +: ROW_BITS] <= '0;
      end
      else
      begin
        if (bankCnt_q[b] != '0)
          bankCnt_q[b] <= bankCnt_q[b] - 1'b1;
        if (cmdRules && cmd == dbc_pkg::CMD_PRE && (ap || bs == 2'(b)))
        begin
          if (bank_q[b] != dbc_pkg::BK_IDLE)
          begin
            bank_q[b] <= dbc_pkg::BK_PRECHARGING;
            bankCnt_q[b] <= CW'(ROW_CLOSE_CYC);
          end
        end
        else if (cmdRules && cmd == dbc_pkg::CMD_BST && burstLive_q && burstBank_q == 2'(b)
                 && bank_q[b] == dbc_pkg::BK_READ)
          bank_q[b] <= dbc_pkg::BK_ACTIVE;
        else if (hit && cmd == dbc_pkg::CMD_ACT && bank_q[b] == dbc_pkg::BK_IDLE)
        begin
          bank_q[b] <= dbc_pkg::BK_ACTIVATING;
          bankCnt_q[b] <= CW'(ROW_TO_COL_CYC);
          openRows[b*ROW_BITS +: ROW_BITS] <= address.addr;
        end
        else if (hit && (cmd == dbc_pkg::CMD_READ || cmd == dbc_pkg::CMD_WRITE)
                 && (bank_q[b] == dbc_pkg::BK_ACTIVE || bank_q[b] == dbc_pkg::BK_READ
                     || bank_q[b] == dbc_pkg::BK_WRITE))
        begin
          if (cmd == dbc_pkg::CMD_READ)
          begin
            bank_q[b] <= ap ? dbc_pkg::BK_READ_AP : dbc_pkg::BK_READ;
            bankCnt_q[b] <= CW'(burstHalf);
          end
          else
          begin
            bank_q[b] <= ap ? dbc_pkg::BK_WRITE_AP : dbc_pkg::BK_WRITE;
            bankCnt_q[b] <= CW'(burstHalf) + CW'(1) + CW'(WRITE_REC_CYC);
          end
        end
        else if (bankCnt_q[b] <= CW'(1))
        begin
          case (bank_q[b])
            dbc_pkg::BK_ACTIVATING, dbc_pkg::BK_READ, dbc_pkg::BK_WRITE:
              bank_q[b] <= dbc_pkg::BK_ACTIVE;
            dbc_pkg::BK_READ_AP, dbc_pkg::BK_WRITE_AP:
            begin
              bank_q[b] <= dbc_pkg::BK_PRECHARGING;
              bankCnt_q[b] <= CW'(ROW_CLOSE_CYC);
            end
            dbc_pkg::BK_PRECHARGING:
              bank_q[b] <= dbc_pkg::BK_IDLE;
            default: bank_q[b] <= bank_q[b];
          endcase
        end
      end
    end
    assign bankStates[b*4 +: 4] = 4'(bank_q[b]);
  end

  // start column and illegal flag registered
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      burstColumn <= '0;
      illegalCmd <= 1'b0;
    end
    else
    begin
      if (cmdRules && (cmd == dbc_pkg::CMD_READ || cmd == dbc_pkg::CMD_WRITE))
        burstColumn <= address.addr;
      illegalCmd <= cmdRules && (((cmd == dbc_pkg::CMD_REF || cmd == dbc_pkg::CMD_MLOAD)
                    && !allIdle) || (cmd == dbc_pkg::CMD_READ && dllCnt_q != '0));
    end
  end

  assign powerState = pwr_q;
  assign dllLocked = dllCnt_q == '0;

  a_deselect_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
    (strobes.csN && pwr_q == dbc_pkg::PW_NORMAL) |=> $stable(modeReg))
    else $error("mode register changed under deselect");
  a_sr_entry: assert property (@(posedge sys_clk) disable iff (!rstn)
    (pwr_q == dbc_pkg::PW_NORMAL && cke_q && !clockEnable && cmd == dbc_pkg::CMD_REF && allIdle)
    |=> pwr_q == dbc_pkg::PW_SELF_REF)
    else $error("self refresh not entered");
  a_pd_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    (pwr_q == dbc_pkg::PW_PRE_PD && !cke_q && !clockEnable) |=> pwr_q == dbc_pkg::PW_PRE_PD)
    else $error("power-down left with clock enable low");
  a_act_opens: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cmdRules && cmd == dbc_pkg::CMD_ACT && bs == 2'd0 && bank_q[0] == dbc_pkg::BK_IDLE)
    |=> bank_q[0] == dbc_pkg::BK_ACTIVATING ##[1:8] bank_q[0] == dbc_pkg::BK_ACTIVE)
    else $error("bank 0 did not open row");
  a_close_all: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cmdRules && cmd == dbc_pkg::CMD_PRE && address.addr[`DBC_CLOSE_ALL_BIT]
     && bank_q[3] == dbc_pkg::BK_ACTIVE) |=> bank_q[3] == dbc_pkg::BK_PRECHARGING)
    else $error("close all missed bank 3");
  a_dll_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cmdRules && cmd == dbc_pkg::CMD_MLOAD && allIdle && bs == 2'b00
     && address.addr[`DBC_DLL_RESET_BIT])
    |=> !modeReg[`DBC_DLL_RESET_BIT] && !dllLocked)
    else $error("loop reset bit held");
  a_read_ap: assert property (@(posedge sys_clk) disable iff (!rstn)
    (bank_q[1] == dbc_pkg::BK_READ_AP && bankCnt_q[1] <= CW'(1)
     && !(cmdRules && cmd == dbc_pkg::CMD_PRE))
    |=> bank_q[1] == dbc_pkg::BK_PRECHARGING)
    else $error("auto precharge period not started");
  a_no_cmd_lowpwr: assert property (@(posedge sys_clk) disable iff (!rstn)
    (pwr_q == dbc_pkg::PW_SR_EXIT) |=> $stable(modeReg) && $stable(openRows))
    else $error("commands taken during exit time");
endmodule // dbc_bank_state

/* File: test/dbc_ctrl_model.sv */
// controller model: drives ddr commands and idle cycles at falling edges
// assumes the bench orders commands and keeps their spacing
`timescale 1ns/1ps
module dbc_ctrl_model (
  input wire logic sys_clk,
  output dbc_pkg::dbc_strobe_type strobes,
  output dbc_pkg::dbc_addr_type address,
  output logic clockEnable
);
  initial
  begin
    strobes = 4'hF;
    address = 16'h0000;
    clockEnable = 1'b1;
  end
  task automatic issue(input dbc_pkg::dbc_cmd_type c, input logic [1:0] b,
    input logic [13:0] a, input logic ce = 1'b1);
    @(negedge sys_clk);
    case (c)
      dbc_pkg::CMD_ACT: strobes = 4'h3;
      dbc_pkg::CMD_READ: strobes = 4'h5;
      dbc_pkg::CMD_WRITE: strobes = 4'h4;
      dbc_pkg::CMD_PRE: strobes = 4'h2;
      dbc_pkg::CMD_BST: strobes = 4'h6;
      dbc_pkg::CMD_MLOAD: strobes = 4'h0;
      dbc_pkg::CMD_REF: strobes = 4'h1;
      default: strobes = 4'h7;
    endcase
    address = {b, a};
    clockEnable = ce;
  endtask
  // no write data lines here, so no mask to drive
  // deselected cycles; unused lines change every cycle
  task automatic pause(input int n, input logic [15:0] fill, input logic ce);
    for (int i = 0; i < n; i++)
    begin
      @(negedge sys_clk);
      strobes = {1'b1, fill[2:0] ^ i[2:0]};
      address = fill ^ 16'(i);
      clockEnable = ce;
    end
  endtask
endmodule // dbc_ctrl_model

/* File: test/ddr_bank_command_state_test.sv */
// self-checking bench for the ddr bank command state block
// assumes dbc_ctrl_model plays the memory controller
`timescale 1ns/1ps
module ddr_bank_command_state_test;
  localparam int RC = 1;
  localparam int RCD = 1;
  localparam int WR = 1;
  localparam logic [13:0] MODE = 14'h0123;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic clockEnable;
  dbc_pkg::dbc_strobe_type strobes;
  dbc_pkg::dbc_addr_type address;
  logic [15:0] bankStates;
  logic [55:0] openRows;
  logic [13:0] modeReg;
  logic [13:0] extModeReg;
  logic [13:0] burstColumn;
  dbc_pkg::dbc_power_type powerState;
  logic dllLocked;
  logic illegalCmd;
  logic [15:0] rnd = 16'h000F;
  int err_count = 0;
  int checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  dbc_ctrl_model ctrl (
    .sys_clk(sys_clk),
    .strobes(strobes),
    .address(address),
    .clockEnable(clockEnable)
  );
  dbc_bank_state #(
    .ROW_CLOSE_CYC(RC),
    .ROW_TO_COL_CYC(RCD),
    .WRITE_REC_CYC(WR)
  ) dut (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clockEnable(clockEnable),
    .strobes(strobes),
    .address(address),
    .bankStates(bankStates),
    .openRows(openRows),
    .modeReg(modeReg),
    .extModeReg(extModeReg),
    .burstColumn(burstColumn),
    .powerState(powerState),
    .dllLocked(dllLocked),
    .illegalCmd(illegalCmd)
  );
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // cycles in the access period of an auto precharge burst
  function automatic int apLen(input logic wr);
    return (1 << MODE[2:0]) / 2 + (wr ? 1 + WR : 0);
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n, input logic ce = 1'b1);
    rnd = lfsr(rnd);
    ctrl.pause(n, rnd, ce);
  endtask
  task automatic track(input logic [1:0] b, input dbc_pkg::dbc_bank_type s, input int n);
    repeat (n)
    begin
      idle(1);
      chk(16'(bankStates[4*b+:4]), 16'(s));
    end
  endtask
  // bounded wait for normal power or a locked loop
  task automatic waitFor(input logic lock, input int lim, output int n);
    for (n = 0; n < lim && !(lock ? dllLocked === 1'b1 :
      powerState === dbc_pkg::PW_NORMAL); n++)
      idle(1);
    chk(16'(n < lim), 16'h0001);
    if (n >= lim)
      final_report();
  endtask
  task automatic refused(input dbc_pkg::dbc_cmd_type c, input logic [1:0] b);
    logic seen;
    ctrl.issue(c, b, 14'h0001);
    idle(1);
    seen = illegalCmd;
    idle(1);
    chk(16'(seen | illegalCmd), 16'h0001);
  endtask
  initial
  begin
    logic [1:0] b;
    logic [13:0] row;
    int n;
    repeat (16) @(negedge sys_clk);
    rstn = 1'b1;
    idle(2);
    chk(bankStates, 16'h0000);
    ctrl.issue(dbc_pkg::CMD_MLOAD, 2'h0, MODE);
    idle(2);
    ctrl.issue(dbc_pkg::CMD_MLOAD, 2'h1, 14'h0002);
    idle(2);
    chk(16'(extModeReg), 16'h0002);
    chk(16'(modeReg), 16'(MODE & 14'h3EFF));
    waitFor(1'b1, 300, n);
    $display("test mode load finished");
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      b = rnd[1:0];
      row = rnd[15:2];
      ctrl.issue(dbc_pkg::CMD_ACT, b, row);
      track(b, dbc_pkg::BK_ACTIVATING, RCD);
      track(b, dbc_pkg::BK_ACTIVE, 1);
      chk(16'(openRows[14*b+:14]), 16'(row));
      ctrl.issue(i[0] ? dbc_pkg::CMD_WRITE : dbc_pkg::CMD_READ, b, row | 14'h0400);
      track(b, i[0] ? dbc_pkg::BK_WRITE_AP : dbc_pkg::BK_READ_AP, 1);
      chk(16'(burstColumn[9:0]), 16'(row[9:0]));
      track(b, i[0] ? dbc_pkg::BK_WRITE_AP : dbc_pkg::BK_READ_AP, apLen(i[0]) - 1);
      track(b, dbc_pkg::BK_PRECHARGING, RC);
      track(b, dbc_pkg::BK_IDLE, 1);
    end
    $display("test random bursts finished");
    for (int k = 0; k < 4; k++)
      ctrl.issue(dbc_pkg::CMD_ACT, 2'(k), 14'(k));
    idle(3);
    ctrl.issue(dbc_pkg::CMD_READ, 2'h1, 14'h0008);
    track(2'h1, dbc_pkg::BK_READ, 1);
    ctrl.issue(dbc_pkg::CMD_BST, 2'h1, 14'h0000);
    track(2'h1, dbc_pkg::BK_ACTIVE, 1);
    chk(16'(bankStates[11:8]), 16'(dbc_pkg::BK_ACTIVE));
    ctrl.issue(dbc_pkg::CMD_READ, 2'h2, 14'h0000);
    track(2'h2, dbc_pkg::BK_READ, apLen(1'b0));
    track(2'h2, dbc_pkg::BK_ACTIVE, 1);
    ctrl.issue(dbc_pkg::CMD_READ, 2'h2, 14'h0400);
    ctrl.issue(dbc_pkg::CMD_PRE, 2'h1, 14'h0000);
    track(2'h1, dbc_pkg::BK_PRECHARGING, RC);
    track(2'h1, dbc_pkg::BK_IDLE, 1);
    chk(16'(bankStates[11:8]), 16'(dbc_pkg::BK_READ_AP));
    idle(3);
    ctrl.issue(dbc_pkg::CMD_ACT, 2'h1, 14'h0001);
    ctrl.issue(dbc_pkg::CMD_ACT, 2'h2, 14'h0002);
    idle(3);
    ctrl.issue(dbc_pkg::CMD_PRE, rnd[1:0], 14'h0400);
    idle(1);
    chk(bankStates, 16'h7777);
    idle(RC);
    chk(bankStates, 16'h0000);
    $display("test bank overlap finished");
    ctrl.issue(dbc_pkg::CMD_ACT, 2'h0, 14'h0005);
    idle(2);
    refused(dbc_pkg::CMD_MLOAD, 2'h0);
    refused(dbc_pkg::CMD_REF, 2'h0);
    chk(16'(modeReg), 16'(MODE & 14'h3EFF));
    ctrl.issue(dbc_pkg::CMD_NOP, 2'h0, 14'h0000, 1'b0);
    idle(1, 1'b0);
    chk(16'(powerState), 16'(dbc_pkg::PW_ACT_PD));
    ctrl.issue(dbc_pkg::CMD_NOP, 2'h0, 14'h0000);
    idle(1);
    chk(16'(powerState), 16'(dbc_pkg::PW_NORMAL));
    ctrl.issue(dbc_pkg::CMD_PRE, 2'h0, 14'h0000);
    idle(2);
    for (int k = 0; k < 2; k++)
    begin
      ctrl.issue(k ? dbc_pkg::CMD_REF : dbc_pkg::CMD_NOP, 2'h0, 14'h0000, 1'b0);
      idle(4, 1'b0);
      chk(16'(powerState), k ? 16'(dbc_pkg::PW_SELF_REF) : 16'(dbc_pkg::PW_PRE_PD));
      ctrl.issue(dbc_pkg::CMD_NOP, 2'h0, 14'h0000);
      waitFor(1'b0, 10, n);
    end
    ctrl.issue(dbc_pkg::CMD_ACT, 2'h3, 14'h0003);
    idle(2);
    refused(dbc_pkg::CMD_READ, 2'h3);
    waitFor(1'b1, 300, n);
    chk(16'(n > 180), 16'h0001);
    ctrl.issue(dbc_pkg::CMD_READ, 2'h3, 14'h0000);
    track(2'h3, dbc_pkg::BK_READ, 1);
    $display("test power states finished");
    final_report();
  end
endmodule // ddr_bank_command_state_test
